// [common/adc_port_pkg.sv]
// constants, types and helpers for the stereo converter serial output port
package adc_port_pkg;
  localparam int         CLK_HZ       = 20_000_000;
  localparam int         PD_MIN_NS    = 150;
  localparam int         PD_MIN_CYC   = (PD_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int         SAMPLE_W     = 20;
  localparam int         PAIR_W       = 2 * SAMPLE_W;
  localparam int         FIFO_DEPTH   = 8;
  localparam int         HPF_SHIFT    = 13;
  localparam int         ACC_W        = SAMPLE_W + HPF_SHIFT + 2;
  localparam logic [2:0] DIV_256      = 3'h4;
  localparam logic [2:0] DIV_384      = 3'h6;
  localparam logic [4:0] STROBE_FIRST = 5'h01;
  localparam logic [4:0] STROBE_LAST  = 5'h10;
  localparam logic [4:0] POS_MAX      = 5'h1f;
  localparam logic [5:0] HALF_FRAME   = 6'h20;
  localparam logic [5:0] RESYNC_TOL   = 6'h04;
  localparam logic [9:0] WARMUP_RISES = 10'h204;
  localparam logic [9:0] SLAVE_RISES  = 10'h205;

  typedef enum logic [1:0] {
    ST_WAIT_EDGE = 2'b00,
    ST_WARMUP    = 2'b01,
    ST_RUN       = 2'b11
  } start_st_t;

  // bit of the word shown at a position, zero outside the 20 data slots
  function automatic logic pick_bit(input logic [SAMPLE_W-1:0] word,
                                    input logic [4:0]          pos,
                                    input logic                delay);
    logic [4:0] idx;
    idx = pos - {4'h0, delay};
    if (pos < {4'h0, delay} || idx >= 5'(SAMPLE_W)) begin
      return 1'b0;
    end
    return word[5'(SAMPLE_W - 1) - idx];
  endfunction : pick_bit

  function automatic logic [SAMPLE_W-1:0] sat_sample(input logic signed [SAMPLE_W+1:0] v);
    logic signed [SAMPLE_W+1:0] hi;
    logic signed [SAMPLE_W+1:0] lo;
    hi = (SAMPLE_W + 2)'((1 << (SAMPLE_W - 1)) - 1);
    lo = -hi - 1;
    if (v > hi) begin
      return hi[SAMPLE_W-1:0];
    end
    if (v < lo) begin
      return lo[SAMPLE_W-1:0];
    end
    return v[SAMPLE_W-1:0];
  endfunction : sat_sample
endpackage : adc_port_pkg

// [common/sample_fifo_if.sv]
// handshake bundle between the sample stage and its fifo
interface sample_fifo_if #(parameter int W = 40);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport user  (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
  modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface : sample_fifo_if

// [verilog/sample_fifo.sv]
// sample pair fifo with registered read word
module sample_fifo #(
  parameter int W     = 40,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic      i_clk,
  input wire logic      i_nrst,
  // fill and drain sides
  sample_fifo_if.store  f
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("sample_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic [W-1:0]  out_r, out_nxt;
  logic          out_v_r, out_v_nxt, ready_r, ready_nxt, push, take;

  assign f.wr_ready = ready_r;
  assign f.rd_valid = out_v_r;
  assign f.rd_data  = out_r;

  always_comb begin
    push      = f.wr_valid && ready_r;
    take      = (cnt_r != '0) && (!out_v_r || f.rd_ready);
    wp_nxt    = push ? wp_r + 1'b1 : wp_r;
    rp_nxt    = take ? rp_r + 1'b1 : rp_r;
    cnt_nxt   = cnt_r + (AW + 1)'(push) - (AW + 1)'(take);
    out_nxt   = take ? mem[rp_r] : out_r;
    out_v_nxt = take || (out_v_r && !f.rd_ready);
    ready_nxt = cnt_nxt < (AW + 1)'(DEPTH);
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r] <= f.wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r    <= '0;
      rp_r    <= '0;
      cnt_r   <= '0;
      out_r   <= '0;
      out_v_r <= 1'b0;
      ready_r <= 1'b1;
    end else begin
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      cnt_r   <= cnt_nxt;
      out_r   <= out_nxt;
      out_v_r <= out_v_nxt;
      ready_r <= ready_nxt;
    end
  end

  property p_fifo_full_refuses;
    @(posedge i_clk) disable iff (!i_nrst)
    cnt_r == (AW + 1)'(DEPTH) |-> !f.wr_ready;
  endproperty
  a_fifo_full_refuses: assert property (p_fifo_full_refuses) else $error("fifo full but ready");
  c_fifo_full: cover property (@(posedge i_clk) disable iff (!i_nrst) cnt_r == (AW + 1)'(DEPTH));
endmodule : sample_fifo

// [verilog/adc_serial_port.sv]
// serial output port of a stereo converter: framing, start-up and dc removal
module adc_serial_port
  import adc_port_pkg::*;
#(
  parameter int         FIFO_WORDS  = FIFO_DEPTH,
  parameter logic [9:0] START_RISES = WARMUP_RISES
) (
  // clock and power-down reset
  input  wire logic                i_clk,
  input  wire logic                i_nrst,
  // configuration pins
  input  wire logic                i_clock_ratio_select,
  input  wire logic                i_master_slave_select,
  input  wire logic                i_format_select,
  input  wire logic                i_dc_filter_enable,
  // converted samples from the decimator
  input  wire logic                i_sample_valid,
  input  wire logic [SAMPLE_W-1:0] i_sample_left,
  input  wire logic [SAMPLE_W-1:0] i_sample_right,
  output logic                     o_sample_ready,
  // serial link pins
  input  wire logic                i_word_select_clock,
  output logic                     o_word_select_clock,
  output logic                     o_word_select_clock_oe,
  input  wire logic                i_bit_clock,
  output logic                     o_bit_clock,
  output logic                     o_bit_clock_oe,
  input  wire logic                i_frame_strobe,
  output logic                     o_frame_strobe,
  output logic                     o_frame_strobe_oe,
  output logic                     o_serial_sample_out,
  // status
  output logic                     o_data_valid,
  output logic                     o_resync
);
  if (FIFO_WORDS < 2) begin : g_chk
    $error("adc_serial_port needs at least two fifo words");
  end
  if (START_RISES < 10'h002 || START_RISES == 10'h3ff) begin : g_chk_rises
    $error("adc_serial_port start-up count out of range");
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sample_fifo_if #(.W(PAIR_W)) fq ();

  sample_fifo #(.W(PAIR_W), .DEPTH(FIFO_WORDS)) u_fifo (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .f      (fq.store)
  );

  // ---- input stage with dc-removal high-pass per channel
  logic [PAIR_W-1:0]   raw, filt, stage_r, stage_nxt;
  logic                stage_v_r, stage_v_nxt, ready_nxt, accept, drain;

  assign raw = {i_sample_left, i_sample_right};

  for (genvar ch = 0; ch < 2; ch++) begin : g_hpf
    logic signed [ACC_W-1:0]    acc_r, acc_nxt, xs, diff;
    logic signed [SAMPLE_W+1:0] y;
    logic        [SAMPLE_W-1:0] x;
    always_comb begin
      x       = raw[ch*SAMPLE_W +: SAMPLE_W];
      xs      = {{2{x[SAMPLE_W-1]}}, x, {HPF_SHIFT{1'b0}}};
      diff    = xs - acc_r;
      acc_nxt = accept ? acc_r + (diff >>> HPF_SHIFT) : acc_r;
      y       = {{2{x[SAMPLE_W-1]}}, x} - acc_r[HPF_SHIFT +: SAMPLE_W + 2];
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        acc_r <= '0;
      end else begin
        acc_r <= acc_nxt;
      end
    end
    // pin pull-up makes an open enable run the filter
    assign filt[ch*SAMPLE_W +: SAMPLE_W] = i_dc_filter_enable ? sat_sample(y) : x;
  end

  always_comb begin
    accept      = i_sample_valid && o_sample_ready;
    drain       = stage_v_r && fq.wr_ready;
    stage_nxt   = accept ? filt : stage_r;
    stage_v_nxt = accept || (stage_v_r && !drain);
    ready_nxt   = !stage_v_nxt;
  end

  assign fq.wr_valid = stage_v_r;
  assign fq.wr_data  = stage_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      stage_r        <= '0;
      stage_v_r      <= 1'b0;
      o_sample_ready <= 1'b0;
    end else begin
      stage_r        <= stage_nxt;
      stage_v_r      <= stage_v_nxt;
      o_sample_ready <= ready_nxt;
    end
  end

  property p_bypass;
    i_sample_valid && o_sample_ready && !i_dc_filter_enable
      |=> stage_r == $past(raw);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered sample");

  // ---- internal sample timing from the master clock
  logic       master, i2s, left_lvl;
  logic [2:0] div, half, sub_r, sub_nxt;
  logic [5:0] bitn_r, bitn_nxt, expect_rise, phase;
  logic       fall, bck_prev_r, wsc_prev_r, bfall, wedge, wrise, drift, resync_nxt;
  start_st_t  st_r, st_nxt;

  always_comb begin
    master      = i_master_slave_select;
    i2s         = i_format_select;
    left_lvl    = !i_format_select;
    div         = i_clock_ratio_select ? DIV_384 : DIV_256;
    half        = div >> 1;
    fall        = sub_r == half - 3'h1;
    bfall       = bck_prev_r && !i_bit_clock;
    wedge       = wsc_prev_r != i_word_select_clock;
    wrise       = !wsc_prev_r && i_word_select_clock;
    expect_rise = left_lvl ? 6'h00 : HALF_FRAME;
    phase       = bitn_r - expect_rise;
    drift       = phase > RESYNC_TOL && phase < 6'h00 - RESYNC_TOL;
    sub_nxt     = (sub_r >= div - 3'h1) ? 3'h0 : sub_r + 3'h1;
    bitn_nxt    = fall ? bitn_r + 6'h01 : bitn_r;
    resync_nxt  = 1'b0;
    // timing runs from release; slave aligns to the word clock rise
    if (!master && wrise && (st_r == ST_WAIT_EDGE || drift)) begin
      sub_nxt    = 3'h0;
      bitn_nxt   = expect_rise;
      resync_nxt = st_r != ST_WAIT_EDGE;
    end
  end

  // ---- start-up sequence
  logic [9:0] rises_r, rises_nxt;
  logic       mrise, word_select_clock_nxt;

  always_comb begin
    word_select_clock_nxt  = left_lvl ^ bitn_nxt[5];
    mrise     = master && word_select_clock_nxt && !o_word_select_clock;
    st_nxt    = st_r;
    rises_nxt = rises_r;
    unique case (st_r)
      ST_WAIT_EDGE: begin
        // master word clock may rise on the very first edge; it counts
        rises_nxt = {9'h000, mrise};
        if (master || wrise) begin
          st_nxt = ST_WARMUP;
        end
      end
      ST_WARMUP: begin
        if (master ? mrise : wrise) begin
          rises_nxt = rises_r + 10'h001;
          if (rises_nxt == START_RISES) begin
            st_nxt = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        st_nxt = ST_RUN;
      end
      default: begin
        st_nxt = ST_WAIT_EDGE;
      end
    endcase
  end

  // ---- channel framing and bit selection
  logic              edge_evt, edge_left, adv, delay, left_r, left_nxt, sd_nxt;
  logic [4:0]        pos_r, pos_nxt;
  logic [PAIR_W-1:0] hold_r, hold_nxt;
  logic [SAMPLE_W-1:0] word;

  always_comb begin
    if (master) begin
      edge_evt  = fall && bitn_nxt[4:0] == 5'h00;
      edge_left = !bitn_nxt[5];
      adv       = fall && !edge_evt;
    end else begin
      edge_evt  = wedge;
      edge_left = i_word_select_clock == left_lvl;
      adv       = bfall && !wedge && (i2s || i_frame_strobe);
    end
    delay       = master || i2s;
    fq.rd_ready = edge_evt && edge_left;
    hold_nxt    = hold_r;
    if (fq.rd_ready) begin
      hold_nxt = fq.rd_valid ? fq.rd_data : '0;
    end
    left_nxt = edge_evt ? edge_left : left_r;
    pos_nxt  = pos_r;
    if (edge_evt) begin
      pos_nxt = 5'h00;
    end else if (adv && pos_r != POS_MAX) begin
      pos_nxt = pos_r + 5'h01;
    end
    word   = left_nxt ? hold_nxt[PAIR_W-1 -: SAMPLE_W] : hold_nxt[SAMPLE_W-1:0];
    sd_nxt = (st_nxt == ST_RUN) && pick_bit(word, pos_nxt, delay);
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sub_r                  <= 3'h0;
      bitn_r                 <= 6'h00;
      bck_prev_r             <= 1'b0;
      wsc_prev_r             <= 1'b0;
      st_r                   <= ST_WAIT_EDGE;
      rises_r                <= '0;
      pos_r                  <= 5'h00;
      left_r                 <= 1'b0;
      hold_r                 <= '0;
      o_serial_sample_out    <= 1'b0;
      o_bit_clock            <= 1'b0;
      o_word_select_clock    <= 1'b0;
      o_frame_strobe         <= 1'b0;
      o_bit_clock_oe         <= 1'b0;
      o_word_select_clock_oe <= 1'b0;
      o_frame_strobe_oe      <= 1'b0;
      o_data_valid           <= 1'b0;
      o_resync               <= 1'b0;
    end else begin
      sub_r                  <= sub_nxt;
      bitn_r                 <= bitn_nxt;
      bck_prev_r             <= i_bit_clock;
      wsc_prev_r             <= i_word_select_clock;
      st_r                   <= st_nxt;
      rises_r                <= rises_nxt;
      pos_r                  <= pos_nxt;
      left_r                 <= left_nxt;
      hold_r                 <= hold_nxt;
      o_serial_sample_out    <= sd_nxt;
      o_bit_clock            <= master && (sub_nxt < half);
      o_word_select_clock    <= master && word_select_clock_nxt;
      o_frame_strobe         <= master && bitn_nxt[4:0] >= STROBE_FIRST
                                && bitn_nxt[4:0] <= STROBE_LAST;
      o_bit_clock_oe         <= master;
      o_word_select_clock_oe <= master;
      o_frame_strobe_oe      <= master;
      o_data_valid           <= st_nxt == ST_RUN;
      o_resync               <= resync_nxt;
    end
  end

  // ---- checks
  logic [9:0] seen_r;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_r <= '0;
    end else if ((master ? mrise : wrise) && seen_r != 10'h3ff) begin
      seen_r <= seen_r + 10'h001;
    end
  end

  property p_master_drives;
    i_master_slave_select |=> o_bit_clock_oe && o_word_select_clock_oe && o_frame_strobe_oe;
  endproperty
  a_master_drives: assert property (p_master_drives) else $error("master pins not driven");

  property p_ratio_high;
    // the first bit clock pulse after release is short, before the pins were driven
    $rose(o_bit_clock) && master && !i_clock_ratio_select && $past(o_bit_clock_oe)
      |-> o_bit_clock[*2] ##1 !o_bit_clock;
  endproperty
  a_ratio_high: assert property (p_ratio_high) else $error("256 fs bit clock wrong");

  property p_ratio_low;
    $fell(o_bit_clock) && master && i_clock_ratio_select |-> !o_bit_clock[*3] ##1 o_bit_clock;
  endproperty
  a_ratio_low: assert property (p_ratio_low) else $error("384 fs bit clock wrong");

  property p_data_on_fall;
    master && $changed(o_serial_sample_out) |-> $fell(o_bit_clock);
  endproperty
  a_data_on_fall: assert property (p_data_on_fall) else $error("data moved off falling edge");

  property p_strobe_rise;
    master && !i_clock_ratio_select && $changed(o_word_select_clock) && $past(o_bit_clock_oe)
      |-> !o_frame_strobe[*4] ##1 o_frame_strobe;
  endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("strobe not one bit late");

  property p_strobe_len;
    master && !i_clock_ratio_select && $rose(o_frame_strobe) |-> ##64 $fell(o_frame_strobe);
  endproperty
  a_strobe_len: assert property (p_strobe_len) else $error("strobe not 16 bits");

  property p_left_level;
    master && edge_evt && edge_left |=> o_word_select_clock == left_lvl;
  endproperty
  a_left_level: assert property (p_left_level) else $error("left channel polarity wrong");

  property p_hold_no_strobe;
    !master && !i2s && bfall && !wedge && !i_frame_strobe |=> $stable(o_serial_sample_out);
  endproperty
  a_hold_no_strobe: assert property (p_hold_no_strobe) else $error("advanced without strobe");

  property p_startup;
    $rose(o_data_valid) |-> seen_r == (master ? START_RISES : START_RISES + 10'h001);
  endproperty
  a_startup: assert property (p_startup) else $error("start-up count wrong");

  property p_resync_cause;
    o_resync |-> !$past(master) && $past(i_word_select_clock) && !$past(i_word_select_clock, 2);
  endproperty
  a_resync_cause: assert property (p_resync_cause) else $error("resync without word rise");

  c_master_run: cover property (master && $rose(o_data_valid));
  c_slave_run:  cover property (!master && $rose(o_data_valid));
  c_resync:     cover property (o_resync);
endmodule : adc_serial_port

// [dv/slave_host_model.sv]
// slave-mode host: word clock, bit clock and frame strobe made from the master clock
module slave_host_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // control
  input  wire logic       i_run,
  input  wire logic       i_slip,
  input  wire logic [7:0] i_slip_amt,
  // link clocks
  output logic            o_word_select_clock,
  output logic            o_bit_clock,
  output logic            o_frame_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] phase_r;
  // 256 master clocks a frame, 4 a bit: clocks locked, 256 fs ratio only
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_r <= 8'h00;
    end else if (i_run) begin
      phase_r <= phase_r + 8'h01 + (i_slip ? i_slip_amt : 8'h00);
    end
  end
  // clocks run while i_run is high and reset is released, stand still otherwise
  always_comb begin
    o_bit_clock         = i_run & ~phase_r[1];
    o_word_select_clock = i_run & ~phase_r[7];
    o_frame_strobe      = i_run & (phase_r[6:2] < 5'h14);
  end
endmodule : slave_host_model

// [dv/adc_serial_port_tb.sv]
// self-checking bench for the serial output port
module adc_serial_port_tb;
  import adc_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DLY = 5;
  localparam logic [19:0] XL = 20'h12345;
  localparam logic [19:0] XR = 20'h9abcd;
  // shortened start-up count keeps the run brief; the default count is the documented one
  localparam logic [9:0]  WARM = 10'h040;
  typedef struct packed {
    logic       ratio;
    logic       ms;
    logic       fmt;
    logic [3:0] per;
  } cfg_row_t;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ratio = 1'b0;
  logic ms = 1'b1;
  logic fmt = 1'b0;
  logic hpf = 1'b1;
  logic run = 1'b0;
  logic slip = 1'b0;
  logic [7:0] slip_amt = 8'h00;
  logic wsc_in, bck_in, fs_in, ready;
  logic wsc, wsc_oe, bck, bck_oe, fs, fs_oe, sdo, dvalid, resync;
  int error_cnt = 0;
  int n_compared = 0;
  int wsc_rises, since_wsc, resync_cnt;
  logic wsc_prev, early_data;
  cfg_row_t rows [6] = '{'{1'b0, 1'b1, 1'b0, 4'h4}, '{1'b1, 1'b1, 1'b0, 4'h6},
                         '{1'b0, 1'b1, 1'b1, 4'h4}, '{1'b1, 1'b1, 1'b1, 4'h6},
                         '{1'b0, 1'b0, 1'b0, 4'h0}, '{1'b0, 1'b0, 1'b1, 4'h0}};

  always #25 i_clk = ~i_clk;

  adc_serial_port #(.START_RISES(WARM)) adc_serial_port_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_clock_ratio_select(ratio),
    .i_master_slave_select(ms), .i_format_select(fmt), .i_dc_filter_enable(hpf),
    .i_sample_valid(1'b1), .i_sample_left(XL), .i_sample_right(XR), .o_sample_ready(ready),
    .i_word_select_clock(wsc_in), .o_word_select_clock(wsc), .o_word_select_clock_oe(wsc_oe),
    .i_bit_clock(bck_in), .o_bit_clock(bck), .o_bit_clock_oe(bck_oe),
    .i_frame_strobe(fs_in), .o_frame_strobe(fs), .o_frame_strobe_oe(fs_oe),
    .o_serial_sample_out(sdo), .o_data_valid(dvalid), .o_resync(resync));

  slave_host_model slave_host_model_i (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_run(run), .i_slip(slip), .i_slip_amt(slip_amt),
    .o_word_select_clock(wsc_in), .o_bit_clock(bck_in), .o_frame_strobe(fs_in));

  // link observers: word rises, cycles since a word edge, early data, resync pulses
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wsc_rises <= 0;
      since_wsc <= 0;
      resync_cnt <= 0;
      wsc_prev <= 1'b0;
      early_data <= 1'b0;
    end else begin
      wsc_prev <= wsc;
      since_wsc <= (wsc !== wsc_prev) ? 0 : since_wsc + 1;
      if (wsc && !wsc_prev) wsc_rises <= wsc_rises + 1;
      if (!dvalid && sdo) early_data <= 1'b1;
      if (resync) resync_cnt <= resync_cnt + 1;
    end
  end

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return bck;
      1: return fs;
      2: return wsc;
      4: return wsc_in;
      default: return dvalid;
    endcase
  endfunction : pick

  // cycles until the selected output reaches a level, bounded
  task automatic wait_lvl(input int sel, input logic lvl, output int cyc, input int lim);
    cyc = 0;
    while (pick(sel) !== lvl && cyc < lim) begin
      @(posedge i_clk);
      #DLY;
      cyc++;
    end
    if (pick(sel) !== lvl) begin
      error_cnt++;
      $display("unexpected wait on output %0d: level never reached", sel);
    end
  endtask : wait_lvl

  task automatic apply(input cfg_row_t r, input logic filt);
    @(posedge i_clk);
    #DLY;
    i_nrst = 1'b0;
    run = 1'b0;
    {ratio, ms, fmt, hpf} = {r.ratio, r.ms, r.fmt, filt};
    repeat (3) @(posedge i_clk);
    #DLY;
    check("valid in reset", 20'(dvalid), 20'h0);
    check("ready in reset", 20'(ready), 20'h0);
    i_nrst = 1'b1;
    run = !r.ms;
  endtask : apply

  task automatic capture(output logic [19:0] w, output logic ch);
    int c;
    wait_lvl(1, 1'b0, c, 600);
    wait_lvl(1, 1'b1, c, 600);
    ch = wsc;
    for (int i = 19; i >= 0; i--) begin
      wait_lvl(0, 1'b0, c, 20);
      wait_lvl(0, 1'b1, c, 20);
      w[i] = sdo;
      check("strobe during bit", 20'(fs), 20'(i >= 4));
    end
  endtask : capture

  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(2_500_000);
    error_cnt++;
    $display("unexpected hang: watchdog expired");
    report_and_stop();
  end

  initial begin
    int a, b;
    logic [19:0] w;
    logic [19:0] w2;
    logic ch;
    logic ch2;
    for (int k = 0; k < 6; k++) begin
      apply(rows[k], 1'b1);
      repeat (2) @(posedge i_clk);
      #DLY;
      check("oe set", 20'({wsc_oe, bck_oe, fs_oe}), 20'({3{rows[k].ms}}));
      if (rows[k].ms) begin
        wait_lvl(1, 1'b1, a, 600);
        check("left level", 20'(wsc), 20'(!rows[k].fmt));
        wait_lvl(1, 1'b0, a, 600);
        check("strobe high", 20'(a), 20'(16 * rows[k].per));
        wait_lvl(1, 1'b1, a, 600);
        check("strobe delay", 20'(since_wsc), 20'(rows[k].per - 1));
        wait_lvl(0, 1'b0, a, 20);
        wait_lvl(0, 1'b1, a, 20);
        wait_lvl(0, 1'b0, a, 20);
        wait_lvl(0, 1'b1, b, 20);
        check("bit high", 20'(a), 20'(rows[k].per / 2));
        check("bit period", 20'(a + b), 20'(rows[k].per));
      end else begin
        repeat (300) @(posedge i_clk);
        #DLY;
        check("master pins idle", 20'({wsc, bck, fs}), 20'h0);
      end
      $display("test row %0d done", k);
    end
    apply(rows[0], 1'b1);
    wait_lvl(3, 1'b1, a, 20_000);
    repeat (2) @(posedge i_clk);
    #DLY;
    check("word rises at valid", 20'(wsc_rises), 20'(WARM));
    check("data before valid", 20'(early_data), 20'h0);
    capture(w, ch);
    if (!ch) capture(w, ch);
    check("filtered below input", 20'(w < XL), 20'h1);
    hpf = 1'b0;
    repeat (3000) @(posedge i_clk);
    #DLY;
    capture(w, ch);
    if (!ch) capture(w, ch);
    capture(w2, ch2);
    check("left word", w, XL);
    check("right word", w2, XR);
    check("right level", 20'(ch2), 20'h0);
    $display("test master data done");
    apply(rows[4], 1'b0);
    repeat (1500) @(posedge i_clk);
    #DLY;
    a = resync_cnt;
    slip_amt = 8'h10;
    slip = 1'b1;
    @(posedge i_clk);
    #DLY;
    slip = 1'b0;
    repeat (600) @(posedge i_clk);
    #DLY;
    check("resync within tolerance", 20'(resync_cnt - a), 20'h0);
    slip_amt = 8'h40;
    slip = 1'b1;
    @(posedge i_clk);
    #DLY;
    slip = 1'b0;
    repeat (400) @(posedge i_clk);
    #DLY;
    check("resync on drift", 20'(resync_cnt - a), 20'h1);
    $display("test slave resync done");
    // justified slave: msb follows the word edge, later bits each bit clock fall while the frame strobe is high
    wait_lvl(3, 1'b1, a, 20_000);
    wait_lvl(4, 1'b0, a, 300);
    wait_lvl(4, 1'b1, a, 300);
    for (int i = 19; i >= 0; i--) begin
      repeat ((i == 19) ? 2 : 4) @(posedge i_clk);
      #DLY;
      w[i] = sdo;
    end
    check("slave left word", w, XL);
    $display("test slave data done");
    report_and_stop();
  end
endmodule : adc_serial_port_tb
